//--- verilog/css_pkg.sv
// constants, types and decode helper for the clocked serial slave receiver
// assumes a single 100 MHz clock domain and an 8-bit register port
package css_pkg;

    // ==========================================================
    // register map (word index on the register port)
    localparam logic [2:0] CSS_ADDR_STBY  = 3'h0; // standby_control_reg
    localparam logic [2:0] CSS_ADDR_START = 3'h1; // channel_start_reg
    localparam logic [2:0] CSS_ADDR_STOP  = 3'h2; // channel_stop_reg
    localparam logic [2:0] CSS_ADDR_IRQ   = 3'h3; // request, enable, level
    localparam logic [2:0] CSS_ADDR_BUSY  = 3'h4; // handshake output value
    localparam logic [2:0] CSS_ADDR_RXBUF = 3'h5; // received word
    localparam logic [2:0] CSS_ADDR_STAT  = 3'h6; // channel state

    // ==========================================================
    // field positions
    localparam int CSS_BIT_SNZ_EN   = 0;
    localparam int CSS_BIT_TRIG     = 0;
    localparam int CSS_BIT_IRQ_PEND = 0;
    localparam int CSS_BIT_IRQ_EN   = 1;
    localparam int CSS_BIT_PRIO_LO  = 2;
    localparam int CSS_BIT_PRIO_HI  = 3;
    localparam int CSS_BIT_BUSY     = 0;
    localparam int CSS_BIT_ST_CHAN  = 0;
    localparam int CSS_BIT_ST_AUTO  = 1;
    localparam int CSS_BIT_ST_VALID = 2;
    localparam int CSS_BIT_ST_SHIFT = 3;

    // ==========================================================
    // reset values and sizes
    localparam logic       CSS_RST_SNZ_EN = 1'b0;
    localparam logic       CSS_RST_IRQ_EN = 1'b0;
    localparam logic [1:0] CSS_RST_PRIO   = 2'h0;
    localparam logic       CSS_RST_BUSY   = 1'b1;
    localparam int         CSS_WORD_BITS  = 8;

    typedef enum logic [1:0] {
        CSS_RX_IDLE,
        CSS_RX_WAIT,
        CSS_RX_SHIFT
    } css_rx_e;

    function automatic logic css_hit(input logic [2:0] addr,
                                     input logic [2:0] offs,
                                     input logic       stb);
        return stb && (addr == offs);
    endfunction

endpackage

//--- verilog/css_rx.sv
// clocked serial slave receiver with stop-mode autonomous reception
// assumes slave_clock_in and serial_data_in come from an outside master;
// stop_mode and fast_osc_sel come from on-chip logic on the same clock
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module css_rx
    import css_pkg::*;
#(
    parameter int WORD_BITS = CSS_WORD_BITS
) (
    input  wire logic       clock,           // 100 MHz system clock
    input  wire logic       nrst,            // async reset, active low
    input  wire logic [2:0] reg_addr,        // register index
    input  wire logic [7:0] reg_wdata,       // write data
    input  wire logic       reg_wr,          // write strobe
    input  wire logic       reg_rd,          // read strobe
    output logic      [7:0] reg_rdata,       // read data, cycle after read
    input  wire logic       slave_clock_in,  // serial clock from master
    input  wire logic       serial_data_in,  // serial data from master
    input  wire logic       stop_mode,       // processor is in stop mode
    input  wire logic       fast_osc_sel,    // fast oscillator is clock source
    output logic            busy_out,        // handshake, 1 = not ready
    output logic            transfer_end_irq, // pending and enabled request
    output logic            autonomous_receive_state, // receiving in stop
    output logic            wake_req         // one-cycle wake pulse
);

    if (WORD_BITS < 2 || WORD_BITS > 8) begin : g_bad_width
        $error("css_rx: WORD_BITS must lie between 2 and 8");
    end

    // ==========================================================
    // pin synchronisers
    logic       sck_s1_ff, sck_s2_ff, sck_d_ff;
    logic       sdi_s1_ff, sdi_s2_ff;
    logic       sck_rise, sck_fall;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_s1_ff <= 1'b1;
            sck_s2_ff <= 1'b1;
            sck_d_ff  <= 1'b1;
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
        end else begin
            sck_s1_ff <= slave_clock_in;
            sck_s2_ff <= sck_s1_ff;
            sck_d_ff  <= sck_s2_ff;
            sdi_s1_ff <= serial_data_in;
            sdi_s2_ff <= sdi_s1_ff;
        end
    end

    assign sck_rise = sck_s2_ff && !sck_d_ff;
    assign sck_fall = !sck_s2_ff && sck_d_ff;

    // ==========================================================
    // register strobes
    logic wr_stby, wr_start, wr_stop, wr_irq, wr_busy, rd_rxbuf;

    assign wr_stby  = css_hit(reg_addr, CSS_ADDR_STBY, reg_wr);
    assign wr_start = css_hit(reg_addr, CSS_ADDR_START, reg_wr) &&
                      reg_wdata[CSS_BIT_TRIG];
    assign wr_stop  = css_hit(reg_addr, CSS_ADDR_STOP, reg_wr) &&
                      reg_wdata[CSS_BIT_TRIG];
    assign wr_irq   = css_hit(reg_addr, CSS_ADDR_IRQ, reg_wr);
    assign wr_busy  = css_hit(reg_addr, CSS_ADDR_BUSY, reg_wr);
    assign rd_rxbuf = css_hit(reg_addr, CSS_ADDR_RXBUF, reg_rd);

    // ==========================================================
    // configuration
    logic       snz_en_ff;
    logic       irq_en_ff;
    logic [1:0] prio_ff;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            snz_en_ff <= CSS_RST_SNZ_EN;
        else if (wr_stby)
            snz_en_ff <= reg_wdata[CSS_BIT_SNZ_EN];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_en_ff <= CSS_RST_IRQ_EN;
            prio_ff   <= CSS_RST_PRIO;
        end else if (wr_irq) begin
            irq_en_ff <= reg_wdata[CSS_BIT_IRQ_EN];
            prio_ff   <= reg_wdata[CSS_BIT_PRIO_HI:CSS_BIT_PRIO_LO];
        end
    end

    // ==========================================================
    // receive state machine
    css_rx_e    state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic       auto_ff;
    logic       rx_allowed;
    logic       word_done;
    logic       auto_entry;

    // in stop mode the channel only starts, shifts and completes a word once the autonomous state is on
    assign rx_allowed = !stop_mode || auto_ff;
    assign auto_entry = stop_mode && snz_en_ff && fast_osc_sel &&
                        (state_ff == CSS_RX_WAIT) && sck_fall;
    assign word_done  = rx_allowed && sck_rise &&
                        (state_ff != CSS_RX_IDLE) &&
                        (cnt_ff == 4'(WORD_BITS - 1));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= CSS_RX_IDLE;
            cnt_ff   <= 4'h0;
        end else if (wr_stop) begin
            state_ff <= CSS_RX_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            case (state_ff)
                CSS_RX_IDLE: begin
                    if (wr_start)
                        state_ff <= CSS_RX_WAIT;
                end
                CSS_RX_WAIT: begin
                    if (rx_allowed && sck_rise) begin
                        state_ff <= CSS_RX_SHIFT;
                        cnt_ff   <= 4'h1;
                    end
                end
                CSS_RX_SHIFT: begin
                    if (word_done) begin
                        state_ff <= CSS_RX_WAIT;
                        cnt_ff   <= 4'h0;
                    end else if (sck_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= CSS_RX_IDLE;
                    cnt_ff   <= 4'h0;
                end
            endcase
        end
    end

    // type 1 phase: master moves data on falling edge, slave samples on rise
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            shift_ff <= 8'h00;
        else if (rx_allowed && sck_rise && state_ff != CSS_RX_IDLE)
            shift_ff <= {shift_ff[6:0], sdi_s2_ff};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            auto_ff <= 1'b0;
        else if (word_done || wr_stop || !stop_mode)
            auto_ff <= 1'b0;
        else if (auto_entry)
            auto_ff <= 1'b1;
    end

    // ==========================================================
    // receive buffer, request flag, handshake
    logic [7:0] rxbuf_ff;
    logic       valid_ff;
    logic       pend_ff;
    logic       nxt_pend;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rxbuf_ff <= 8'h00;
            valid_ff <= 1'b0;
        end else if (word_done) begin
            rxbuf_ff <= {shift_ff[6:0], sdi_s2_ff};
            valid_ff <= 1'b1;
        end else if (rd_rxbuf) begin
            valid_ff <= 1'b0;
        end
    end

    // a completion in the clearing cycle keeps the request set
    always_comb begin
        nxt_pend = pend_ff;
        if (wr_irq && reg_wdata[CSS_BIT_IRQ_PEND])
            nxt_pend = 1'b0;
        if (word_done)
            nxt_pend = 1'b1;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            pend_ff <= 1'b0;
        else
            pend_ff <= nxt_pend;
    end

    // the master holds off while busy is high, so no clock arrives then
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            busy_out <= CSS_RST_BUSY;
        else if (wr_busy)
            busy_out <= reg_wdata[CSS_BIT_BUSY];
        else if (rd_rxbuf && valid_ff)
            busy_out <= 1'b1;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            transfer_end_irq         <= 1'b0;
            wake_req                 <= 1'b0;
            autonomous_receive_state <= 1'b0;
        end else begin
            transfer_end_irq         <= nxt_pend && irq_en_ff;
            wake_req                 <= word_done && auto_ff && irq_en_ff;
            autonomous_receive_state <= auto_ff;
        end
    end

    // ==========================================================
    // read port
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            CSS_ADDR_STBY:  rd_mux[CSS_BIT_SNZ_EN] = snz_en_ff;
            CSS_ADDR_IRQ: begin
                rd_mux[CSS_BIT_IRQ_PEND] = pend_ff;
                rd_mux[CSS_BIT_IRQ_EN]   = irq_en_ff;
                rd_mux[CSS_BIT_PRIO_HI:CSS_BIT_PRIO_LO] = prio_ff;
            end
            CSS_ADDR_BUSY:  rd_mux[CSS_BIT_BUSY] = busy_out;
            CSS_ADDR_RXBUF: rd_mux = rxbuf_ff;
            CSS_ADDR_STAT: begin
                rd_mux[CSS_BIT_ST_CHAN]  = (state_ff != CSS_RX_IDLE);
                rd_mux[CSS_BIT_ST_AUTO]  = auto_ff;
                rd_mux[CSS_BIT_ST_VALID] = valid_ff;
                rd_mux[CSS_BIT_ST_SHIFT] = (state_ff == CSS_RX_SHIFT);
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_wait_fall_in_stop;
        stop_mode && snz_en_ff && fast_osc_sel &&
        state_ff == CSS_RX_WAIT && sck_fall && !wr_stop;
    endsequence

    sequence s_word_ends;
        word_done && !wr_stop;
    endsequence

    chk_fall_enters_auto: assert property (
        s_wait_fall_in_stop |=> auto_ff ##1 autonomous_receive_state)
        else $error("falling clock in stop mode did not enter auto state");

    chk_auto_needs_enable: assert property (
        $rose(auto_ff) |-> $past(snz_en_ff) && $past(fast_osc_sel))
        else $error("auto state entered without enable or fast oscillator");

    chk_auto_needs_fall: assert property (
        $rose(auto_ff) |-> $past(sck_fall))
        else $error("auto state entered without a falling clock edge");

    chk_word_sets_pend: assert property (
        s_word_ends |=> pend_ff ##1
            (transfer_end_irq == (pend_ff && $past(irq_en_ff))))
        else $error("completed word did not raise the request");

    chk_auto_leaves: assert property (
        s_word_ends ##0 auto_ff ##0 irq_en_ff |=> !auto_ff && wake_req)
        else $error("auto state not left or wake missing on completion");

    chk_stop_halts: assert property (
        wr_stop |=> state_ff == CSS_RX_IDLE && !auto_ff)
        else $error("stop trigger did not halt the channel");

    chk_start_waits: assert property (
        wr_start && !wr_stop && state_ff == CSS_RX_IDLE
        |=> state_ff == CSS_RX_WAIT)
        else $error("start trigger did not enter the wait state");

    chk_buffer_holds: assert property (
        !word_done |=> $stable(rxbuf_ff))
        else $error("receive buffer changed without a completed word");

    chk_msb_first: assert property (
        word_done |=> rxbuf_ff == $past({shift_ff[6:0], sdi_s2_ff}))
        else $error("received word not assembled msb first");

    chk_busy_after_read: assert property (
        rd_rxbuf && valid_ff |=> busy_out && reg_rdata == $past(rxbuf_ff))
        else $error("busy not raised after the word was read");

    chk_busy_write_low: assert property (
        wr_busy && !reg_wdata[CSS_BIT_BUSY] |=> !busy_out)
        else $error("busy output not driven low for ready");

    chk_no_stop_rx: assert property (
        stop_mode && !auto_ff && state_ff == CSS_RX_WAIT && sck_rise &&
        !wr_stop |=> state_ff == CSS_RX_WAIT)
        else $error("reception started in stop mode without auto state");

endmodule // css_rx

//--- test/css_master.sv
// serial master model for the slave receiver bench
// assumes send() is called only while the link is idle
`timescale 1ns/1ns
module css_master (
    output logic      sck,  // serial clock, idles high
    output logic      sdo,  // serial data, msb first
    input  wire logic busy  // slave handshake, 1 = not ready
);
    // ==========================================================
    // link idle state
    initial begin
        sck = 1'b1;
        sdo = 1'b0;
    end

    // ==========================================================
    // one word, 125 ns period, clock stands still between words
    task automatic send(input logic [7:0] b);
        int i;
        for (i = 0; i < 2000 && busy !== 1'b0; i++) #10;
        if (busy === 1'b0) begin
            // odd half periods: this offset keeps every edge off 0 mod 5
            #2;
            for (i = 7; i >= 0; i--) begin
                sck = 1'b0;
                sdo = b[i];
                #62;
                sck = 1'b1;
                #63;
            end
            // a released line must not keep showing the last bit
            sdo = ~sdo;
        end
    endtask
endmodule // css_master

//--- test/css_rx_bench.sv
// self-checking bench for the clocked serial slave receiver
// assumes css_rx and the css_master link model beside it
`timescale 1ns/1ns
module css_rx_bench;
    import css_pkg::*;
    logic       clock = 1'b0;
    logic       nrst  = 1'b0;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       sck;
    logic       sdi;
    logic       stop_mode;
    logic       fast_osc_sel;
    logic       busy_out;
    logic       transfer_end_irq;
    logic       autonomous_receive_state;
    logic       wake_req;
    logic       rd_d = 1'b0;
    logic [7:0] b;
    logic [7:0] exp_rx;
    logic [7:0] exp_q[$];
    integer     seed = 32'h85450741;
    int         bad_count = 0;
    int         n_checks = 0;
    int         n_auto = 0;
    int         n_wake = 0;
    int         i;
    // reset image of indices 0..7, index 5 is not checked
    logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                              8'h01, 8'h00, 8'h00, 8'h00};
    // {stop_mode, enable, fast osc, two words, stop first}
    logic [4:0] rows [5] = '{5'b00110, 5'b11100, 5'b10100,
                             5'b11000, 5'b00101};

    always #5 clock = ~clock;

    css_rx dut_u (
        .clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .slave_clock_in(sck),
        .serial_data_in(sdi), .stop_mode(stop_mode),
        .fast_osc_sel(fast_osc_sel), .busy_out(busy_out),
        .transfer_end_irq(transfer_end_irq),
        .autonomous_receive_state(autonomous_receive_state),
        .wake_req(wake_req));

    css_master link_u (.sck(sck), .sdo(sdi), .busy(busy_out));

    // ==========================================================
    // compare and report
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pin(input string nm, input logic e, input logic g);
        cmp(nm, {7'h00, e}, {7'h00, g});
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // register port master and read-data watcher
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
    endtask

    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (autonomous_receive_state === 1'b1) n_auto++;
        if (wake_req === 1'b1) n_wake++;
    end

    always @(negedge clock) begin
        if (rd_d === 1'b1) cmp("read data", exp_q.pop_front(), reg_rdata);
    end

    // ==========================================================
    // one armed reception, then the shutdown sequence
    task automatic xfer(input logic [4:0] r);
        logic sm, en, fo, st, ok;
        int   k;
        {sm, en, fo, st} = {r[4:2], r[0]};
        ok = !st && (!sm || (en && fo));
        wr(CSS_ADDR_STBY, {7'h00, en});
        wr(CSS_ADDR_IRQ, 8'h03);
        wr(CSS_ADDR_START, 8'h01);
        if (st) wr(CSS_ADDR_STOP, 8'h01);
        wr(CSS_ADDR_BUSY, 8'h00);
        rd(CSS_ADDR_STAT, {7'h00, !st});
        stop_mode    <= sm;
        fast_osc_sel <= fo;
        @(negedge clock);
        pin("busy ready", 1'b0, busy_out);
        n_auto = 0;
        n_wake = 0;
        for (k = 0; k <= int'(r[1]); k++) begin
            b = $random(seed);
            link_u.send(b);
            if (ok) exp_rx = b;
        end
        for (k = 0; k < 20 && transfer_end_irq !== 1'b1; k++)
            @(negedge clock);
        pin("irq", ok, transfer_end_irq);
        @(negedge clock);
        pin("auto off", 1'b0, autonomous_receive_state);
        pin("auto seen", sm && ok, n_auto != 0);
        cmp("wake count", {7'h00, sm && ok}, n_wake[7:0]);
        @(posedge clock);
        stop_mode    <= 1'b0;
        fast_osc_sel <= 1'b1;
        rd(CSS_ADDR_IRQ, {6'h00, 1'b1, ok});
        rd(CSS_ADDR_RXBUF, exp_rx);
        @(negedge clock);
        pin("busy after read", ok, busy_out);
        wr(CSS_ADDR_STOP, 8'h01);
        wr(CSS_ADDR_IRQ, 8'h01);
        wr(CSS_ADDR_STBY, 8'h00);
        rd(CSS_ADDR_STAT, 8'h00);
        @(negedge clock);
        pin("irq off", 1'b0, transfer_end_irq);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        reg_addr     = 3'h0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        stop_mode    = 1'b0;
        fast_osc_sel = 1'b1;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        pin("busy reset", 1'b1, busy_out);
        pin("irq reset", 1'b0, transfer_end_irq);
        pin("auto reset", 1'b0, autonomous_receive_state);
        for (i = 0; i < 8; i++)
            if (i != 5) rd(i[2:0], rst_v[i]);
        wr(CSS_ADDR_IRQ, 8'h0e);
        rd(CSS_ADDR_IRQ, 8'h0e);
        wr(CSS_ADDR_IRQ, 8'h02);
        rd(CSS_ADDR_IRQ, 8'h02);
        wr(3'h7, 8'h5a);
        rd(3'h7, 8'h00);
        rd(CSS_ADDR_STBY, 8'h00);
        $display("test 0 done");
        for (i = 0; i < 5; i++) begin
            xfer(rows[i]);
            $display("test %0d done", i + 1);
        end
        repeat (4) @(posedge clock);
        test_done();
    end

    // the whole run needs about 820 cycles
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule // css_rx_bench
